// ### design/lpm_pkg.sv
// Shared constants and carrier types for the USB 2.0 link power management handler.
package lpm_pkg;

  localparam int unsigned CLK_HZ = 25000000;
  // Inactivity time before the link counts as suspended, in microseconds.
  localparam int unsigned SUSPEND_IDLE_US = 3000;
  localparam int unsigned SUSPEND_IDLE_CYC = SUSPEND_IDLE_US * (CLK_HZ / 1000000);
  // Resume duration code: base and step in microseconds.
  localparam int unsigned HIRD_BASE_US = 50;
  localparam int unsigned HIRD_STEP_US = 75;
  localparam int unsigned HIRD_W = 4;
  localparam logic [HIRD_W-1:0] HIRD_LIMIT_RST = 4'hF;
  localparam int unsigned DEPTH_W = 2;
  localparam int unsigned US_W = 11;

  typedef enum logic [1:0] {
    LINK_L0 = 2'h0,
    LINK_L1 = 2'h1,
    LINK_L2 = 2'h3
  } link_state_t;

  typedef enum logic [1:0] {
    HS_NONE = 2'h0,
    HS_ACK = 2'h1,
    HS_NYET = 2'h2
  } handshake_t;

  // One decoded LPM extended transaction.
  typedef struct packed {
    logic [HIRD_W-1:0] hird;
    logic remote_wake;
  } lpm_req_t;

endpackage : lpm_pkg

// ### design/hird_decode.sv
// Decoder from resume duration code to microseconds and a power-down depth.
`timescale 1ns/1ps
module hird_decode (
  input wire logic [lpm_pkg::HIRD_W-1:0] hird_i,
  output logic [lpm_pkg::US_W-1:0] dur_us_o,
  output logic [lpm_pkg::DEPTH_W-1:0] depth_o
);

  localparam logic [lpm_pkg::US_W-1:0] BASE = lpm_pkg::US_W'(lpm_pkg::HIRD_BASE_US);
  localparam logic [lpm_pkg::US_W-1:0] STEP = lpm_pkg::US_W'(lpm_pkg::HIRD_STEP_US);

  wire [lpm_pkg::US_W-1:0] code_ext = {{(lpm_pkg::US_W - lpm_pkg::HIRD_W){1'b0}}, hird_i};
  wire [2*lpm_pkg::US_W-1:0] prod = code_ext * STEP;

  // Code 0 gives 50 us, each step adds 75 us, code 15 gives 1175 us.
  assign dur_us_o = BASE + prod[lpm_pkg::US_W-1:0];
  // Longer announced resume lets more of the device be powered down.
  assign depth_o = hird_i[lpm_pkg::HIRD_W-1 -: lpm_pkg::DEPTH_W];

endmodule : hird_decode

// ### design/lpm_l1_handler.sv
// Device-side L1/L2 link state tracking, LPM request judgement and resume handling.
`timescale 1ns/1ps

// Operation
// - Host starts L1; device answers ACK or NYET.
// - Without L1 support, never enter L1.
// - Three ms of bus idle means L2.
// - Either side resumes; detect host resume.
// - Device wake from L1 only if LPM permitted it.
// - HIRD code: 50 us plus 75 us steps.
// - Longer HIRD allows deeper power down.
// - Accept or refuse by pending activity.
// - Refuse when HIRD exceeds tolerated latency.
// - Periodic-endpoint device with L1 support always accepts L1.
// - Idle interrupt endpoint: L1 until device exit.
module lpm_l1_handler #(
  parameter int unsigned IDLE_CYC = lpm_pkg::SUSPEND_IDLE_CYC
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic clk_en_i,
  input wire logic l1_supported_i,
  input wire logic periodic_ep_i,
  input wire logic activity_pending_i,
  input wire logic [lpm_pkg::HIRD_W-1:0] hird_limit_i,
  input wire logic lpm_req_valid_i,
  input wire lpm_pkg::lpm_req_t lpm_req_i,
  input wire logic bus_activity_i,
  input wire logic host_resume_i,
  input wire logic wake_req_i,
  input wire logic resume_done_i,
  output lpm_pkg::handshake_t handshake_o,
  output logic handshake_valid_o,
  output lpm_pkg::link_state_t link_state_o,
  output logic drive_resume_o,
  output logic remote_wake_en_o,
  output logic [lpm_pkg::US_W-1:0] hird_us_o,
  output logic [lpm_pkg::DEPTH_W-1:0] power_depth_o
);

  localparam int unsigned CNT_W = $clog2(IDLE_CYC + 1);
  localparam logic [CNT_W-1:0] IDLE_LAST = CNT_W'(IDLE_CYC - 1);

  // Bus activity and host resume pins pass two flip-flops before use.
  logic act_s1_r, act_s2_r;
  logic hres_s1_r, hres_s2_r;

  lpm_pkg::link_state_t state_r, state_nxt;
  lpm_pkg::handshake_t hs_r, hs_nxt;
  logic hs_v_r;
  logic rw_en_r, rw_en_nxt;
  logic drive_r, drive_nxt;
  logic [CNT_W-1:0] idle_cnt_r, idle_cnt_nxt;
  logic [lpm_pkg::HIRD_W-1:0] hird_r;
  logic [lpm_pkg::US_W-1:0] hird_us;
  logic [lpm_pkg::DEPTH_W-1:0] depth;

  hird_decode u_hird_decode (
    .hird_i(hird_r),
    .dur_us_o(hird_us),
    .depth_o(depth)
  );

  wire in_l0 = (state_r == lpm_pkg::LINK_L0);
  wire in_l1 = (state_r == lpm_pkg::LINK_L1);
  wire in_l2 = (state_r == lpm_pkg::LINK_L2);
  wire take_req = lpm_req_valid_i && in_l0;
  wire hird_too_big = lpm_req_i.hird > hird_limit_i;
  // Periodic devices accept whenever L1 is supported; otherwise pending work or long HIRD refuses.
  wire accept_ok = periodic_ep_i || (!activity_pending_i && !hird_too_big);
  // An unsupported device never answers ACK, so the link never sleeps in L1.
  wire accept = take_req && l1_supported_i && accept_ok;
  wire idle_hit = in_l0 && !act_s2_r && (idle_cnt_r == IDLE_LAST);
  // Device wake from L1 needs the permission captured with the request.
  wire dev_wake_l1 = in_l1 && wake_req_i && rw_en_r && !drive_r;
  wire dev_wake_l2 = in_l2 && wake_req_i && !drive_r;
  wire host_wake = (in_l1 || in_l2) && hres_s2_r;

  always_comb begin
    state_nxt = state_r;
    hs_nxt = lpm_pkg::HS_NONE;
    rw_en_nxt = rw_en_r;
    drive_nxt = drive_r;
    idle_cnt_nxt = idle_cnt_r;
    unique case (state_r)
      lpm_pkg::LINK_L0: begin
        if (act_s2_r || take_req) begin
          idle_cnt_nxt = '0;
        end else if (!idle_hit) begin
          idle_cnt_nxt = idle_cnt_r + 1'b1;
        end
        if (take_req) begin
          hs_nxt = accept ? lpm_pkg::HS_ACK : lpm_pkg::HS_NYET;
          if (accept) begin
            state_nxt = lpm_pkg::LINK_L1;
            rw_en_nxt = lpm_req_i.remote_wake;
          end
        end else if (idle_hit) begin
          state_nxt = lpm_pkg::LINK_L2;
        end
      end
      lpm_pkg::LINK_L1, lpm_pkg::LINK_L2: begin
        if (dev_wake_l1 || dev_wake_l2) begin
          drive_nxt = 1'b1;
        end
        // Either party's resume ends once the link reports it complete.
        if ((drive_r || host_wake) && resume_done_i) begin
          state_nxt = lpm_pkg::LINK_L0;
          drive_nxt = 1'b0;
          rw_en_nxt = 1'b0;
          idle_cnt_nxt = '0;
        end
      end
      default: begin
        state_nxt = lpm_pkg::LINK_L0;
        drive_nxt = 1'b0;
        idle_cnt_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      act_s1_r <= 1'b0;
      act_s2_r <= 1'b0;
      hres_s1_r <= 1'b0;
      hres_s2_r <= 1'b0;
    end else if (clk_en_i) begin
      act_s1_r <= bus_activity_i;
      act_s2_r <= act_s1_r;
      hres_s1_r <= host_resume_i;
      hres_s2_r <= hres_s1_r;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      state_r <= lpm_pkg::LINK_L0;
      hs_r <= lpm_pkg::HS_NONE;
      hs_v_r <= 1'b0;
      rw_en_r <= 1'b0;
      drive_r <= 1'b0;
      idle_cnt_r <= '0;
    end else if (clk_en_i) begin
      state_r <= state_nxt;
      hs_r <= hs_nxt;
      hs_v_r <= take_req;
      rw_en_r <= rw_en_nxt;
      drive_r <= drive_nxt;
      idle_cnt_r <= idle_cnt_nxt;
    end
  end

  // The announced duration is kept from the last accepted request.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      hird_r <= '0;
    end else if (clk_en_i && accept) begin
      hird_r <= lpm_req_i.hird;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      hird_us_o <= '0;
      power_depth_o <= '0;
    end else if (clk_en_i) begin
      hird_us_o <= hird_us;
      power_depth_o <= in_l1 ? depth : '0;
    end
  end

  assign handshake_o = hs_r;
  assign handshake_valid_o = hs_v_r;
  assign link_state_o = state_r;
  assign drive_resume_o = drive_r;
  assign remote_wake_en_o = rw_en_r;

endmodule : lpm_l1_handler

// ### dv/lpm_chk_props.sv
// Port checker for the LPM handler.
`timescale 1ns/1ps
module lpm_chk (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic clk_en_i,
  input wire logic l1_supported_i,
  input wire logic periodic_ep_i,
  input wire logic activity_pending_i,
  input wire logic [3:0] hird_limit_i,
  input wire logic lpm_req_valid_i,
  input wire lpm_pkg::lpm_req_t lpm_req_i,
  input wire lpm_pkg::handshake_t handshake_o,
  input wire logic handshake_valid_o,
  input wire lpm_pkg::link_state_t link_state_o,
  input wire logic drive_resume_o,
  input wire logic remote_wake_en_o,
  input wire logic [10:0] hird_us_o
);
  wire l0 = link_state_o == lpm_pkg::LINK_L0;
  // A request is only taken on an enabled edge, so frozen cycles expect no answer.
  wire tk = lpm_req_valid_i && l0 && clk_en_i;
  wire ack = handshake_valid_o && handshake_o == lpm_pkg::HS_ACK;
  wire nyet = handshake_valid_o && handshake_o == lpm_pkg::HS_NYET;
  wire free = l1_supported_i && !periodic_ep_i;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  a_ack_enters_l1: assert property (ack |-> link_state_o == lpm_pkg::LINK_L1) else $error("ACK not L1");
  a_unsupported_nyet: assert property (tk && !l1_supported_i |=> nyet) else $error("no NYET");
  a_periodic_ack: assert property (tk && l1_supported_i && periodic_ep_i |=> ack) else $error("no ACK");
  a_busy_nyet: assert property (tk && free && activity_pending_i |=> nyet) else $error("busy ACK");
  a_long_hird_nyet: assert property (tk && free && lpm_req_i.hird > hird_limit_i |=> nyet) else $error("HIRD ACK");
  a_wake_permit: assert property ($rose(drive_resume_o) && !l0 |-> remote_wake_en_o || link_state_o == lpm_pkg::LINK_L2) else $error("wake");
  a_quiet_off_l0: assert property (lpm_req_valid_i && !l0 |=> !handshake_valid_o) else $error("answer");
  a_hird_us_value: assert property (ack |=> hird_us_o == 11'(50 + 75 * $past(lpm_req_i.hird, 2))) else $error("us");
  c_ack: cover property (ack);
  c_nyet: cover property (nyet);
  c_l2: cover property (link_state_o == lpm_pkg::LINK_L2);
endmodule : lpm_chk
bind lpm_l1_handler lpm_chk chk (.*);

// ### dv/host_model.sv
// Host model: LPM requests, resume and bus traffic.
`timescale 1ns/1ps
module host_model (
  input wire logic clk_i,
  output lpm_pkg::lpm_req_t req_o,
  output logic vld_o,
  output logic act_o,
  output logic res_o
);
  initial begin
    {req_o, vld_o, act_o, res_o} = 8'h02;
  end
  task automatic send(input logic [4:0] r);
    @(posedge clk_i);
    vld_o <= 1'b1;
    req_o <= r;
    @(posedge clk_i);
    vld_o <= 1'b0;
    req_o <= ~r;
  endtask : send
  task automatic wake(input int n);
    @(posedge clk_i);
    res_o <= 1'b1;
    repeat (n) @(posedge clk_i);
    res_o <= 1'b0;
  endtask : wake
  task automatic busy(input logic a);
    @(posedge clk_i);
    act_o <= a;
  endtask : busy
endmodule : host_model

// ### dv/tb_top.sv
// Bench for the LPM handler against the host model.
`timescale 1ns/1ps
module tb_top;
  logic sys_clk_i, srst_i, ce, sup, per, pend, wk, done, vld, act, res, hv, dr, rwe;
  logic [3:0] lim;
  logic [10:0] us;
  logic [1:0] pd;
  lpm_pkg::lpm_req_t rq;
  lpm_pkg::handshake_t hs;
  lpm_pkg::link_state_t ls;
  int miscompares = 0;
  int samples_checked = 0;
  host_model HM (.clk_i(sys_clk_i), .req_o(rq), .vld_o(vld), .act_o(act), .res_o(res));
  lpm_l1_handler #(.IDLE_CYC(20)) DUT (.sys_clk_i, .srst_i, .clk_en_i(ce), .l1_supported_i(sup),
    .periodic_ep_i(per), .activity_pending_i(pend), .hird_limit_i(lim), .lpm_req_valid_i(vld), .lpm_req_i(rq),
    .bus_activity_i(act), .host_resume_i(res), .wake_req_i(wk), .resume_done_i(done), .handshake_o(hs),
    .handshake_valid_o(hv), .link_state_o(ls), .drive_resume_o(dr), .remote_wake_en_o(rwe), .hird_us_o(us),
    .power_depth_o(pd));
  task automatic chk(input logic [10:0] g, input logic [10:0] e);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %0t got %0h want %0h", $time, g, e);
    end
  endtask : chk
  task automatic cfg(input logic [6:0] c);
    @(posedge sys_clk_i);
    {sup, per, pend, lim} <= c;
  endtask : cfg
  task automatic ask(input logic [4:0] r, input logic [10:0] e);
    HM.send(r);
    #1;
    chk(hv, 1);
    chk(hs, e);
  endtask : ask
  task automatic dev_wake(input logic e);
    @(posedge sys_clk_i);
    wk <= 1'b1;
    @(posedge sys_clk_i);
    wk <= 1'b0;
    #1;
    chk(dr, e);
  endtask : dev_wake
  task automatic resumed;
    @(posedge sys_clk_i);
    done <= 1'b1;
    @(posedge sys_clk_i);
    done <= 1'b0;
    #1;
    chk(ls, lpm_pkg::LINK_L0);
  endtask : resumed
  task automatic t_accept;
    cfg(7'h4F);
    ask(5'h05, lpm_pkg::HS_ACK);
    chk(ls, lpm_pkg::LINK_L1);
    chk(rwe, 1);
    @(posedge sys_clk_i);
    #1;
    chk(us, 200);
    HM.send(5'h00);
    #1;
    chk(hv, 0);
    dev_wake(1);
    resumed();
    $display("accept test done");
  endtask : t_accept
  task automatic t_refuse;
    cfg(7'h0F);
    ask(5'h02, lpm_pkg::HS_NYET);
    cfg(7'h5F);
    ask(5'h02, lpm_pkg::HS_NYET);
    cfg(7'h43);
    ask(5'h12, lpm_pkg::HS_NYET);
    ask(5'h06, lpm_pkg::HS_ACK);
    dev_wake(0);
    HM.wake(6);
    resumed();
    cfg(7'h7F);
    ask(5'h18, lpm_pkg::HS_ACK);
    @(posedge sys_clk_i);
    #1;
    chk(pd, 3);
    chk(us, 950);
    HM.wake(4);
    resumed();
    $display("refuse test done");
  endtask : t_refuse
  // A request that arrives while the clock enable is low must leave no trace.
  task automatic t_freeze;
    cfg(7'h4F);
    @(posedge sys_clk_i);
    ce <= 1'b0;
    HM.send(5'h05);
    #1;
    chk(hv, 0);
    chk(ls, lpm_pkg::LINK_L0);
    @(posedge sys_clk_i);
    ce <= 1'b1;
    ask(5'h05, lpm_pkg::HS_ACK);
    dev_wake(1);
    resumed();
    $display("freeze test done");
  endtask : t_freeze
  task automatic t_suspend;
    HM.busy(0);
    repeat (30) @(posedge sys_clk_i);
    #1;
    chk(ls, lpm_pkg::LINK_L2);
    dev_wake(1);
    resumed();
    HM.busy(1);
    $display("suspend test done");
  endtask : t_suspend
  task automatic give_verdict;
    $display("checks %0d bad %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict
  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    #200us;
    miscompares++;
    give_verdict();
  end
  initial begin
    {srst_i, ce, sup, per, pend, lim, wk, done} = 11'h600;
    repeat (2) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    t_accept();
    t_refuse();
    t_freeze();
    t_suspend();
    give_verdict();
  end
endmodule : tb_top
